// ### hw/clock_supervisor_pkg.sv
// constants, types and behaviour summary for the clock supervisor bank
// What this block does
// - units run on the internal rc reference
// - fourteen supervisor units, each with its own window counter
// - out-of-window clock raises fault toward collector
// - detect crystal loss, rc loss, bounds, missing
// - faults withheld until software enables handling
// - unit zero meters rc against crystal
// - start bit reads one while measuring
// - start bit clears when measurement done
// - stopped crystal never finishes measurement
// - reset leaves crystal, plls off; rc clocks system
// - control bits 31:27 pick pll reference
// - pll loss of lock goes to collector
// - unit seven watches rc divided by three
package clock_supervisor_pkg;
    localparam int NUM_UNITS = 14;
    localparam int NUM_PLLS = 5;
    localparam int NUM_PINS = NUM_UNITS - 1;
    localparam int XTAL_UNIT = 0;
    localparam int DIV3_UNIT = 7;
    localparam int CNT_W = 16;
    localparam int CLK_MHZ = 25;
    localparam int WINDOW_NS = 40960;
    localparam int WINDOW_CYCLES = (WINDOW_NS * CLK_MHZ) / 1000;
    localparam int WIN_W = $clog2(WINDOW_CYCLES);
    localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WINDOW_CYCLES - 1);
    localparam int METER_XTAL_EDGES = 256;
    localparam int XE_W = $clog2(METER_XTAL_EDGES);
    localparam logic [XE_W-1:0] XE_LAST = XE_W'(METER_XTAL_EDGES - 1);
    localparam int REF_SEL_HI = 31;
    localparam int REF_SEL_LO = 27;
    localparam logic [1:0] DIV3_LAST = 2'h2;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;

    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_RUN = 2'b01
    } meter_state_e;

    typedef struct packed {
        logic [CNT_W-1:0] lo;
        logic [CNT_W-1:0] hi;
    } unit_bounds_s;

    typedef struct packed {
        logic too_high;
        logic too_low;
        logic lost;
    } unit_fault_s;

    typedef struct packed {
        unit_fault_s [NUM_UNITS-1:0] unit;
        logic [NUM_PLLS-1:0] pll_unlock;
        logic rc_lost;
    } fault_report_s;

    localparam fault_report_s FAULT_NONE = '0;
endpackage

// ### hw/clock_check_unit.sv
// one supervisor unit: edge count per window against bounds
`timescale 1ns/10ps
module clock_check_unit
    import clock_supervisor_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_level,
    input wire logic enable,
    input wire unit_bounds_s bounds,
    output unit_fault_s fault_q,
    output logic [CNT_W-1:0] last_count_q
);
    logic prev_q;
    logic [WIN_W-1:0] win_q;
    logic [CNT_W-1:0] edges_q;
    logic rise;

    assign rise = clk_level & ~prev_q;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            prev_q <= 1'b0;
        else
            prev_q <= clk_level;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            win_q <= '0;
        else if (!enable || win_q == WIN_LAST)
            win_q <= '0;
        else
            win_q <= win_q + 1'b1;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            edges_q <= CNT_ZERO;
        else if (!enable)
            edges_q <= CNT_ZERO;
        // rise on the closing edge opens the next window
        else if (win_q == WIN_LAST)
            edges_q <= CNT_W'(rise);
        else if (rise && edges_q != CNT_MAX)
            edges_q <= edges_q + 1'b1;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fault_q <= '0;
            last_count_q <= CNT_ZERO;
        end
        else if (!enable)
            fault_q <= '0;
        else if (win_q == WIN_LAST)
        begin
            last_count_q <= edges_q;
            fault_q.too_high <= edges_q > bounds.hi;
            fault_q.too_low <= edges_q < bounds.lo;
            fault_q.lost <= edges_q == CNT_ZERO;
        end
    end
endmodule

// ### hw/clock_monitor_freq_meter.sv
// clock supervisor bank, rc frequency meter and clock source defaults
`timescale 1ns/10ps
module clock_monitor_freq_meter
    import clock_supervisor_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [NUM_PINS-1:0] mon_clk_pins,
    input wire logic [NUM_PLLS-1:0] pll_locked,
    input wire logic [NUM_UNITS-1:0] unit_enable,
    input wire unit_bounds_s [NUM_UNITS-1:0] unit_bounds,
    input wire logic fault_handling_enable,
    input wire logic start_measure_wr,
    input wire logic xosc_enable,
    input wire logic [NUM_PLLS-1:0] pll_enable,
    input wire logic sysclk_use_pll,
    input wire logic [31:0] general_purpose_control_one,
    output fault_report_s fault_to_collector_q,
    output logic start_measure_bit_q,
    output logic [CNT_W-1:0] meter_result_q,
    output logic xosc_power_q,
    output logic [NUM_PLLS-1:0] pll_power_q,
    output logic sysclk_from_pll_q,
    output logic [REF_SEL_HI-REF_SEL_LO:0] pll_ref_sel_q,
    output logic rc_div3_clock_q
);
    logic [NUM_PINS-1:0] pin_s1_q;
    logic [NUM_PINS-1:0] pin_s2_q;
    logic [NUM_PLLS-1:0] lock_s1_q;
    logic [NUM_PLLS-1:0] lock_s2_q;
    logic [NUM_UNITS-1:0] unit_clk;
    unit_fault_s [NUM_UNITS-1:0] unit_fault;
    logic [1:0] div3_q;
    logic fault_en_q;
    meter_state_e meter_q;
    logic xtal_prev_q;
    logic meter_armed_q;
    logic [XE_W-1:0] xtal_edges_q;
    logic [CNT_W-1:0] rc_count_q;
    logic xtal_rise;
    logic meter_done;
    fault_report_s report_d;

    function automatic logic rising(input logic cur, input logic prev);
        rising = cur & ~prev;
    endfunction

    // pins pass two flip-flops first
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            lock_s1_q <= '0;
            lock_s2_q <= '0;
        end
        else
        begin
            pin_s1_q <= mon_clk_pins;
            pin_s2_q <= pin_s1_q;
            lock_s1_q <= pll_locked;
            lock_s2_q <= lock_s1_q;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            div3_q <= 2'h0;
        else if (div3_q == DIV3_LAST)
            div3_q <= 2'h0;
        else
            div3_q <= div3_q + 2'h1;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            rc_div3_clock_q <= 1'b0;
        else
            rc_div3_clock_q <= div3_q == 2'h0;
    end

    genvar g;
    generate
        for (g = 0; g < NUM_UNITS; g++)
        begin : g_unit
            if (g == DIV3_UNIT)
            begin : g_div3
                assign unit_clk[g] = rc_div3_clock_q;
            end
            else if (g < DIV3_UNIT)
            begin : g_lo
                assign unit_clk[g] = pin_s2_q[g];
            end
            else
            begin : g_hi
                assign unit_clk[g] = pin_s2_q[g-1];
            end
            clock_check_unit u_check (
                .mclk(mclk),
                .sys_rst(sys_rst),
                .clk_level(unit_clk[g]),
                .enable(unit_enable[g]),
                .bounds(unit_bounds[g]),
                .fault_q(unit_fault[g]),
                .last_count_q()
            );
        end
    endgenerate

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            fault_en_q <= 1'b0;
        else
            fault_en_q <= fault_handling_enable;
    end

    always_comb
    begin
        report_d = FAULT_NONE;
        report_d.unit = unit_fault;
        report_d.pll_unlock = pll_power_q & ~lock_s2_q;
        report_d.rc_lost = unit_fault[DIV3_UNIT].lost;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            fault_to_collector_q <= FAULT_NONE;
        else if (fault_en_q)
            fault_to_collector_q <= report_d;
        else
            fault_to_collector_q <= FAULT_NONE;
    end

    assign xtal_rise = rising(pin_s2_q[XTAL_UNIT], xtal_prev_q);
    assign meter_done = meter_q == M_RUN && meter_armed_q && xtal_rise && xtal_edges_q == XE_LAST;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            xtal_prev_q <= 1'b0;
        else
            xtal_prev_q <= pin_s2_q[XTAL_UNIT];
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            meter_q <= M_IDLE;
        else
        begin
            case (meter_q)
                M_IDLE:
                begin
                    if (start_measure_wr)
                        meter_q <= M_RUN;
                end
                M_RUN:
                begin
                    if (meter_done && !start_measure_wr)
                        meter_q <= M_IDLE;
                end
                default:
                    meter_q <= M_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            start_measure_bit_q <= 1'b0;
        else if (start_measure_wr)
            start_measure_bit_q <= 1'b1;
        else if (meter_done)
            start_measure_bit_q <= 1'b0;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            xtal_edges_q <= '0;
            rc_count_q <= CNT_ZERO;
        end
        else if (start_measure_wr)
        begin
            xtal_edges_q <= '0;
            rc_count_q <= CNT_ZERO;
        end
        else if (meter_q == M_RUN && (meter_armed_q || xtal_rise))
        begin
            if (rc_count_q != CNT_MAX)
                rc_count_q <= rc_count_q + 1'b1;
            if (xtal_rise && meter_armed_q)
                xtal_edges_q <= xtal_edges_q + 1'b1;
        end
    end

    // first crystal rise opens the gate, whole periods only
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            meter_armed_q <= 1'b0;
        else if (start_measure_wr || meter_done)
            meter_armed_q <= 1'b0;
        else if (meter_q == M_RUN && xtal_rise)
            meter_armed_q <= 1'b1;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            meter_result_q <= CNT_ZERO;
        else if (start_measure_wr)
            meter_result_q <= CNT_ZERO;
        else if (meter_done)
            meter_result_q <= rc_count_q;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            xosc_power_q <= 1'b0;
            pll_power_q <= '0;
            sysclk_from_pll_q <= 1'b0;
        end
        else
        begin
            xosc_power_q <= xosc_enable;
            pll_power_q <= pll_enable;
            sysclk_from_pll_q <= sysclk_use_pll & xosc_enable & xosc_power_q & (|(pll_enable & pll_power_q));
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            pll_ref_sel_q <= '0;
        else
            pll_ref_sel_q <= general_purpose_control_one[REF_SEL_HI:REF_SEL_LO];
    end
endmodule

// ### verif/clock_source_model.sv
// monitored clock sources driving the supervisor pins
`timescale 1ns/10ps
module clock_source_model
(
    input wire logic [12:0] run,
    input wire logic [12:0] fast,
    output logic [12:0] pins
);
    logic slow_clk = 1'b0;
    logic fast_clk = 1'b0;
    always #200.3 slow_clk = ~slow_clk;
    always #100.3 fast_clk = ~fast_clk;
    // stopped source holds low
    assign pins = run & ((fast & {13{fast_clk}}) | (~fast & {13{slow_clk}}));
endmodule

// ### verif/clock_monitor_freq_meter_properties.sv
// assertions on the supervisor bank ports
`timescale 1ns/10ps
module clock_monitor_freq_meter_checker
    import clock_supervisor_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic fault_handling_enable,
    input wire logic start_measure_wr,
    input wire logic xosc_enable,
    input wire logic [31:0] general_purpose_control_one,
    input wire fault_report_s fault_to_collector_q,
    input wire logic start_measure_bit_q,
    input wire logic [CNT_W-1:0] meter_result_q,
    input wire logic xosc_power_q,
    input wire logic [NUM_PLLS-1:0] pll_power_q,
    input wire logic sysclk_from_pll_q,
    input wire logic [REF_SEL_HI-REF_SEL_LO:0] pll_ref_sel_q,
    input wire logic rc_div3_clock_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    chk_ref_sel_copy: assert property (
        pll_ref_sel_q == $past(general_purpose_control_one[31:27])) else $error("pll ref select wrong");
    chk_fault_gated: assert property (
        !fault_handling_enable [*3] |-> fault_to_collector_q == FAULT_NONE) else $error("fault passed while off");
    chk_start_sets: assert property (
        start_measure_wr |=> start_measure_bit_q && meter_result_q == CNT_ZERO) else $error("start not taken");
    chk_result_hold: assert property (
        !start_measure_bit_q && !$past(start_measure_bit_q) && !$past(start_measure_wr) |-> $stable(meter_result_q))
        else $error("result changed");
    chk_div3_period: assert property (
        rc_div3_clock_q |=> !rc_div3_clock_q ##1 !rc_div3_clock_q ##1 rc_div3_clock_q) else $error("div3 bad");
    chk_sysclk_needs: assert property (
        sysclk_from_pll_q |-> xosc_power_q && (|pll_power_q)) else $error("pll clock while off");
    chk_xosc_follow: assert property (
        xosc_power_q == $past(xosc_enable)) else $error("crystal power wrong");
    chk_unlock_power: assert property (
        (fault_to_collector_q.pll_unlock & ~pll_power_q & ~$past(pll_power_q) & ~$past(pll_power_q, 2)) == '0)
        else $error("unlock from unpowered pll");
endmodule
bind clock_monitor_freq_meter clock_monitor_freq_meter_checker u_chk (.mclk(mclk), .sys_rst(sys_rst),
    .fault_handling_enable(fault_handling_enable), .start_measure_wr(start_measure_wr), .xosc_enable(xosc_enable),
    .general_purpose_control_one(general_purpose_control_one), .fault_to_collector_q(fault_to_collector_q),
    .start_measure_bit_q(start_measure_bit_q), .meter_result_q(meter_result_q), .xosc_power_q(xosc_power_q),
    .pll_power_q(pll_power_q), .sysclk_from_pll_q(sysclk_from_pll_q), .pll_ref_sel_q(pll_ref_sel_q),
    .rc_div3_clock_q(rc_div3_clock_q));

// ### verif/tb_clock_monitor_freq_meter.sv
// self-checking bench for the clock supervisor bank
`timescale 1ns/10ps
module tb_clock_monitor_freq_meter
    import clock_supervisor_pkg::*;
;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [12:0] run, fast, pins;
    logic [4:0] pll_locked, pll_enable, pll_power_q;
    logic [13:0] unit_enable;
    unit_bounds_s [13:0] unit_bounds;
    logic fhe, smw, xosc_enable, sysclk_use_pll, xosc_power_q, sysclk_from_pll_q, start_bit, div3;
    logic [31:0] gpc;
    fault_report_s fault;
    logic [15:0] result;
    logic [4:0] ref_sel;
    int n_errors = 0;
    int total_checks = 0;
    always #20 mclk = ~mclk;
    clock_source_model u_src (.run(run), .fast(fast), .pins(pins));
    clock_monitor_freq_meter u_dut (.mclk(mclk), .sys_rst(sys_rst), .mon_clk_pins(pins), .pll_locked(pll_locked),
        .unit_enable(unit_enable), .unit_bounds(unit_bounds), .fault_handling_enable(fhe), .start_measure_wr(smw),
        .xosc_enable(xosc_enable), .pll_enable(pll_enable), .sysclk_use_pll(sysclk_use_pll),
        .general_purpose_control_one(gpc), .fault_to_collector_q(fault), .start_measure_bit_q(start_bit),
        .meter_result_q(result), .xosc_power_q(xosc_power_q), .pll_power_q(pll_power_q),
        .sysclk_from_pll_q(sysclk_from_pll_q), .pll_ref_sel_q(ref_sel), .rc_div3_clock_q(div3));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #(20000 * 40);
        n_errors++;
        complete_run();
    end
    initial
    begin
        {fast, pll_locked, pll_enable, unit_enable, unit_bounds, fhe, smw, xosc_enable, sysclk_use_pll, gpc} = '0;
        run = 13'h1fff;
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'b0;
        chk({xosc_power_q, pll_power_q, sysclk_from_pll_q, |fault}, 32'h0);
        gpc = 32'ha800_0000;
        tick(2);
        chk(ref_sel, 32'h15);
        gpc = 32'h57ff_ffff;
        tick(2);
        chk(ref_sel, 32'h0a);
        $display("test defaults done");
        smw = 1'b1;
        tick(1);
        smw = 1'b0;
        chk(start_bit, 32'h1);
        for (int i = 0; i < 4000 && start_bit !== 1'b0; i++)
            tick(1);
        chk(start_bit, 32'h0);
        // compare with 256 crystal periods of 400.6 ns
        chk(result >= 16'd2555 && result <= 16'd2572, 32'h1);
        tick(20);
        chk(result >= 16'd2555 && result <= 16'd2572, 32'h1);
        $display("test meter done");
        for (int k = 0; k < 14; k++)
            unit_bounds[k] = '{lo: 16'd90, hi: 16'd115};
        unit_bounds[7] = '{lo: 16'd330, hi: 16'd350};
        unit_bounds[1].lo = 16'd200;
        fast[2] = 1'b1;
        run[0] = 1'b0;
        fhe = 1'b1;
        unit_enable = 14'h3fff;
        tick(3200);
        chk(fault.unit[0].lost, 32'h1);
        chk(fault.unit[1].too_low, 32'h1);
        chk(fault.unit[2].too_high, 32'h1);
        chk(fault.unit[7], 32'h0);
        chk(fault.rc_lost, 32'h0);
        chk({fault.unit[8], fault.unit[13]}, 32'h0);
        pll_enable = 5'h1f;
        pll_locked = 5'h0f;
        xosc_enable = 1'b1;
        sysclk_use_pll = 1'b1;
        tick(6);
        chk(fault.pll_unlock, 32'h10);
        chk({xosc_power_q, pll_power_q, sysclk_from_pll_q}, 32'h7f);
        unit_enable[2] = 1'b0;
        tick(4);
        chk(fault.unit[2], 32'h0);
        fhe = 1'b0;
        tick(4);
        chk(|fault, 32'h0);
        $display("test faults done");
        // crystal stopped: meter must hang with the bit set
        smw = 1'b1;
        tick(1);
        smw = 1'b0;
        chk(result, 32'h0);
        tick(3000);
        chk(start_bit, 32'h1);
        $display("test stall done");
        complete_run();
    end
endmodule
